/* File: verilog/adsp_top.v */
/*
 Auto-direction serial port: APB register slave, buffered UART with transmit
 and receive FIFOs, and automatic driver / receiver enable for a shared pair.
 Assumes one clock clk_sys at 100 MHz, an APB3 master, and an external
 transceiver fed by txd, drv_en and rcv_en.
*/
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/10ps
`default_nettype none
`include "adsp_consts.vh"

module adsp_fifo #(
    parameter W  = 8,
    parameter D  = 8,
    parameter AW = 3
) (
    // Clock and reset
    input  wire          clk_sys,
    input  wire          rstn,
    // Fill side
    input  wire          in_valid,
    output wire          in_ready,
    input  wire [W-1:0]  in_data,
    // Drain side
    output wire          out_valid,
    input  wire          out_ready,
    output wire [W-1:0]  out_data
);
    reg  [W-1:0]  mem [0:D-1];
    reg  [AW-1:0] wr_r;
    reg  [AW-1:0] rd_r;
    reg  [AW:0]   cnt_r;
    wire          push;
    wire          pop;

    assign in_ready  = (cnt_r != D[AW:0]);
    assign out_valid = (cnt_r != {(AW+1){1'b0}});
    assign out_data  = mem[rd_r];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always @(posedge clk_sys) begin
        if (push) begin
            mem[wr_r] <= in_data;
        end
    end

    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= (wr_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == D[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

module adsp_top (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rstn,
    // APB slave
    input  wire [11:0] paddr,
    input  wire        psel,
    input  wire        penable,
    input  wire        pwrite,
    input  wire [31:0] pwdata,
    output reg  [31:0] prdata,
    output reg         pready,
    output reg         pslverr,
    // Range select and line
    input  wire        range_4x,
    input  wire        rxd,
    output reg         txd,
    output reg         drv_en,
    output reg         rcv_en
);
    localparam TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h2, TX_PAR = 3'h3;
    localparam TX_STOP = 3'h4, TX_HOLD = 3'h5;
    localparam RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h2, RX_PAR = 3'h3;
    localparam RX_STOP = 3'h4;

    reg  [5:0]  fmt_r;
    reg  [15:0] div_r;
    reg  [2:0]  err_r;
    reg  [2:0]  rx_sync_r;
    reg         rx_filt_r;
    reg  [2:0]  rng_sync_r;
    reg         rng_r;
    reg  [15:0] div_cnt_r;
    reg  [1:0]  pre_cnt_r;
    reg         tick_r;
    reg  [2:0]  tx_st_r;
    reg  [8:0]  tx_cnt_r;
    reg  [2:0]  tx_bit_r;
    reg  [7:0]  tx_sh_r;
    reg  [2:0]  rx_st_r;
    reg  [4:0]  rx_cnt_r;
    reg  [2:0]  rx_bit_r;
    reg  [7:0]  rx_sh_r;
    reg         rx_push_r;
    reg         rx_perr_r;
    reg  [31:0] rd_nxt;
    reg         mapped;

    wire [1:0]  len      = fmt_r[`ADSP_FMT_LEN_HI:`ADSP_FMT_LEN_LO];
    wire        par_en   = fmt_r[`ADSP_FMT_PAR_EN];
    wire        par_odd  = fmt_r[`ADSP_FMT_PAR_ODD];
    wire [1:0]  stop_sel = fmt_r[`ADSP_FMT_STOP_HI:`ADSP_FMT_STOP_LO];
    wire [2:0]  last_bit = {1'b1, len} ;
    wire [7:0]  dmask    = 8'hff >> (2'h3 - len);
    wire [8:0]  stop_ticks;
    wire [8:0]  char_ticks;
    wire        acc      = psel & penable & ~pready;
    wire        done     = psel & penable & pready;
    wire        hit_data = (paddr == `ADSP_OFS_DATA);
    wire        tx_fv;
    wire        tx_fr;
    wire [7:0]  tx_fd;
    wire        rx_fv;
    wire        rx_fr;
    wire [7:0]  rx_fd;
    wire        tx_load;
    wire        tx_bit_end = tick_r & (tx_cnt_r == `ADSP_OVERSAMPLE - 1);
    wire        rx_mid     = tick_r & (rx_cnt_r == `ADSP_OVERSAMPLE - 1);

    // Stop interval in sample ticks
    assign stop_ticks = (stop_sel == 2'h0) ? `ADSP_STOP_1 :
                        (stop_sel == 2'h1) ? `ADSP_STOP_15 : `ADSP_STOP_2;
    // One character: start, data, parity, stop
    assign char_ticks = {1'b0, 4'h6 + {2'h0, len} + {3'h0, par_en}, 4'h0} + stop_ticks;

    // Next char loads straight from the FIFO, so the shifter never idles between
    assign tx_load = tx_fv & ((tx_st_r == TX_IDLE) | (tx_st_r == TX_HOLD) |
                     ((tx_st_r == TX_STOP) & tick_r & (tx_cnt_r == stop_ticks - 1'b1)));

    adsp_fifo #(.W(8), .D(`ADSP_FIFO_DEPTH), .AW(`ADSP_FIFO_AW)) u_tx_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (done & pwrite & hit_data),
        .in_ready  (tx_fr),
        .in_data   (pwdata[7:0]),
        .out_valid (tx_fv),
        .out_ready (tx_load),
        .out_data  (tx_fd)
    );

    adsp_fifo #(.W(8), .D(`ADSP_FIFO_DEPTH), .AW(`ADSP_FIFO_AW)) u_rx_fifo (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .in_valid  (rx_push_r),
        .in_ready  (rx_fr),
        .in_data   (rx_sh_r),
        .out_valid (rx_fv),
        .out_ready (done & ~pwrite & hit_data),
        .out_data  (rx_fd)
    );

    // Read mux
    always @* begin
        rd_nxt = 32'h0000_0000;
        mapped = 1'b1;
        case (paddr)
            `ADSP_OFS_DATA:    rd_nxt[7:0] = rx_fv ? rx_fd : 8'h00;
            `ADSP_OFS_FORMAT:  rd_nxt[5:0] = fmt_r;
            `ADSP_OFS_DIVISOR: rd_nxt[15:0] = div_r;
            `ADSP_OFS_STATUS: begin
                rd_nxt[`ADSP_ST_TX_EMPTY] = ~tx_fv;
                rd_nxt[`ADSP_ST_TX_FULL]  = ~tx_fr;
                rd_nxt[`ADSP_ST_RX_VALID] = rx_fv;
                rd_nxt[`ADSP_ST_TX_BUSY]  = (tx_st_r != TX_IDLE);
                rd_nxt[`ADSP_ST_DRV_EN]   = drv_en;
                rd_nxt[`ADSP_ST_RCV_EN]   = rcv_en;
                rd_nxt[`ADSP_ST_FRM_ERR:`ADSP_ST_OVERRUN] = err_r;
            end
            default: mapped = 1'b0;
        endcase
    end

    // APB slave; a data write waits while the transmit FIFO is full
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
            fmt_r   <= `ADSP_RST_FORMAT;
            div_r   <= `ADSP_RST_DIVISOR;
        end else begin
            pready  <= acc & ~(pwrite & hit_data & ~tx_fr);
            pslverr <= acc & ~mapped;
            if (acc) begin
                prdata <= pwrite ? 32'h0000_0000 : rd_nxt;
            end
            if (done & pwrite & (paddr == `ADSP_OFS_FORMAT)) begin
                fmt_r <= pwdata[5:0];
            end
            if (done & pwrite & (paddr == `ADSP_OFS_DIVISOR)) begin
                div_r <= pwdata[15:0];
            end
        end
    end

    // Sticky errors; a new event beats a write-one clear
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            err_r <= 3'h0;
        end else begin
            err_r <= (err_r & ~((done & pwrite & (paddr == `ADSP_OFS_STATUS)) ?
                     pwdata[`ADSP_ST_FRM_ERR:`ADSP_ST_OVERRUN] : 3'h0)) |
                     {rx_mid & (rx_st_r == RX_STOP) & ~rx_filt_r,
                      rx_mid & (rx_st_r == RX_PAR) & rx_perr_r,
                      rx_push_r & ~rx_fr};
        end
    end

    // Pin synchronisers: accept a level once stages two and three agree
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_sync_r  <= 3'h7;
            rx_filt_r  <= 1'b1;
            rng_sync_r <= 3'h0;
            rng_r      <= 1'b0;
        end else begin
            rx_sync_r  <= {rx_sync_r[1:0], rxd};
            rng_sync_r <= {rng_sync_r[1:0], range_4x};
            if (rx_sync_r[1] == rx_sync_r[2]) begin
                rx_filt_r <= rx_sync_r[2];
            end
            if (rng_sync_r[1] == rng_sync_r[2]) begin
                rng_r <= rng_sync_r[2];
            end
        end
    end

    // Sample tick: divisor, then a divide by four unless the fast range is picked
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            div_cnt_r <= 16'h0000;
            pre_cnt_r <= 2'h0;
            tick_r    <= 1'b0;
        end else begin
            tick_r <= 1'b0;
            if (div_cnt_r + 16'h0001 >= div_r) begin
                div_cnt_r <= 16'h0000;
                if (rng_r | (pre_cnt_r == `ADSP_SLOW_PRESC - 1)) begin
                    pre_cnt_r <= 2'h0;
                    tick_r    <= 1'b1;
                end else begin
                    pre_cnt_r <= pre_cnt_r + 2'h1;
                end
            end else begin
                div_cnt_r <= div_cnt_r + 16'h0001;
            end
        end
    end

    // Transmitter and direction control
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            tx_st_r  <= TX_IDLE;
            tx_cnt_r <= 9'h000;
            tx_bit_r <= 3'h0;
            tx_sh_r  <= 8'h00;
            txd      <= 1'b1;
            drv_en   <= 1'b0;
            rcv_en   <= 1'b1;
        end else begin
            if (tick_r) begin
                tx_cnt_r <= tx_cnt_r + 9'h001;
            end
            if (tx_load) begin
                tx_st_r  <= TX_START;
                tx_cnt_r <= 9'h000;
                tx_bit_r <= 3'h0;
                tx_sh_r  <= tx_fd & dmask;
                txd      <= 1'b0;
                drv_en   <= 1'b1;
                rcv_en   <= 1'b0;
            end else begin
                case (tx_st_r)
                    TX_IDLE: begin
                        txd <= 1'b1;
                    end
                    TX_START: begin
                        if (tx_bit_end) begin
                            tx_st_r  <= TX_DATA;
                            tx_cnt_r <= 9'h000;
                            txd      <= tx_sh_r[0];
                        end
                    end
                    TX_DATA: begin
                        if (tx_bit_end) begin
                            tx_cnt_r <= 9'h000;
                            tx_bit_r <= tx_bit_r + 3'h1;
                            if (tx_bit_r == last_bit) begin
                                tx_st_r <= par_en ? TX_PAR : TX_STOP;
                                txd     <= par_en ? ((^tx_sh_r) ^ par_odd) : 1'b1;
                            end else begin
                                txd <= tx_sh_r[tx_bit_r + 3'h1];
                            end
                        end
                    end
                    TX_PAR: begin
                        if (tx_bit_end) begin
                            tx_st_r  <= TX_STOP;
                            tx_cnt_r <= 9'h000;
                            txd      <= 1'b1;
                        end
                    end
                    TX_STOP: begin
                        if (tick_r & (tx_cnt_r == stop_ticks - 1'b1)) begin
                            tx_st_r  <= TX_HOLD;
                            tx_cnt_r <= 9'h000;
                        end
                    end
                    TX_HOLD: begin
                        if (tick_r & (tx_cnt_r == char_ticks - 1'b1)) begin
                            tx_st_r <= TX_IDLE;
                            drv_en  <= 1'b0;
                            rcv_en  <= 1'b1;
                        end
                    end
                    default: tx_st_r <= TX_IDLE;
                endcase
            end
        end
    end

    // Receiver; ignores the line while disabled
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            rx_st_r   <= RX_IDLE;
            rx_cnt_r  <= 5'h00;
            rx_bit_r  <= 3'h0;
            rx_sh_r   <= 8'h00;
            rx_push_r <= 1'b0;
            rx_perr_r <= 1'b0;
        end else begin
            rx_push_r <= 1'b0;
            if (tick_r) begin
                rx_cnt_r <= rx_cnt_r + 5'h01;
            end
            if (!rcv_en) begin
                rx_st_r <= RX_IDLE;
            end else begin
                case (rx_st_r)
                    RX_IDLE: begin
                        if (!rx_filt_r) begin
                            rx_st_r  <= RX_START;
                            rx_cnt_r <= 5'h00;
                            rx_sh_r  <= 8'h00;
                        end
                    end
                    RX_START: begin
                        if (tick_r & (rx_cnt_r == `ADSP_HALF_BIT - 1)) begin
                            rx_st_r  <= rx_filt_r ? RX_IDLE : RX_DATA;
                            rx_cnt_r <= 5'h00;
                            rx_bit_r <= 3'h0;
                        end
                    end
                    RX_DATA: begin
                        if (rx_mid) begin
                            rx_cnt_r          <= 5'h00;
                            rx_bit_r          <= rx_bit_r + 3'h1;
                            rx_sh_r[rx_bit_r] <= rx_filt_r;
                            if (rx_bit_r == last_bit) begin
                                rx_st_r <= par_en ? RX_PAR : RX_STOP;
                            end
                        end
                    end
                    RX_PAR: begin
                        rx_perr_r <= (^rx_sh_r) ^ par_odd ^ rx_filt_r;
                        if (rx_mid) begin
                            rx_st_r  <= RX_STOP;
                            rx_cnt_r <= 5'h00;
                        end
                    end
                    RX_STOP: begin
                        if (rx_mid) begin
                            rx_st_r   <= RX_IDLE;
                            rx_push_r <= 1'b1;
                        end
                    end
                    default: rx_st_r <= RX_IDLE;
                endcase
            end
        end
    end
endmodule
`default_nettype wire

/* File: include/adsp_consts.vh */
/*
 Constants of the auto-direction serial port: register offsets, field positions,
 reset values and timing counts. Assumes inclusion by bare name.
*/
`ifndef ADSP_CONSTS_VH
`define ADSP_CONSTS_VH
// Register byte offsets
`define ADSP_OFS_DATA     12'h000
`define ADSP_OFS_FORMAT   12'h004
`define ADSP_OFS_DIVISOR  12'h008
`define ADSP_OFS_STATUS   12'h00c
// Format field positions
`define ADSP_FMT_LEN_LO   0
`define ADSP_FMT_LEN_HI   1
`define ADSP_FMT_PAR_EN   2
`define ADSP_FMT_PAR_ODD  3
`define ADSP_FMT_STOP_LO  4
`define ADSP_FMT_STOP_HI  5
// Status field positions
`define ADSP_ST_TX_EMPTY  0
`define ADSP_ST_TX_FULL   1
`define ADSP_ST_RX_VALID  2
`define ADSP_ST_TX_BUSY   3
`define ADSP_ST_DRV_EN    4
`define ADSP_ST_RCV_EN    5
`define ADSP_ST_OVERRUN   8
`define ADSP_ST_PAR_ERR   9
`define ADSP_ST_FRM_ERR   10
// Reset values
`define ADSP_RST_FORMAT   6'h03
`define ADSP_RST_DIVISOR  16'h0001
// Timing counts in sample ticks; the slow prescale counts divisor periods
`define ADSP_OVERSAMPLE   16
`define ADSP_HALF_BIT     8
`define ADSP_STOP_1       9'h010
`define ADSP_STOP_15      9'h018
`define ADSP_STOP_2       9'h020
`define ADSP_SLOW_PRESC   4
// Buffer geometry
`define ADSP_FIFO_DEPTH   16
`define ADSP_FIFO_AW      4
`endif

/* File: dv/adsp_top_sva.sv */
/*
 Checker on the adsp_top ports: line direction switching and APB answer timing.
 Assumes the single clk_sys domain and that it is bound to every adsp_top.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adsp_consts.vh"
module adsp_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rstn,
    // APB
    input wire logic [11:0] paddr,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    // Line
    input wire logic        range_4x,
    input wire logic        rxd,
    input wire logic        txd,
    input wire logic        drv_en,
    input wire logic        rcv_en
);
    int unsigned hi_cnt;
    // Idle run while driving; shortest hold is 5N1 at one clock per tick
    always @(posedge clk_sys or negedge rstn) begin
        if (!rstn)
            hi_cnt <= 0;
        else if (drv_en && txd)
            hi_cnt <= hi_cnt + 1;
        else
            hi_cnt <= 0;
    end
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    chk_rcv_while_drv: assert property (drv_en |-> !rcv_en)
        else $error("receiver enabled while driving");
    chk_txd_idle_off: assert property (!drv_en |-> txd)
        else $error("line not idle with driver off");
    chk_start_bit: assert property ($rose(drv_en) |-> (!txd) [*8])
        else $error("driver on without a start bit");
    chk_rcv_back_on: assert property ($fell(drv_en) |-> $rose(rcv_en))
        else $error("receiver not re-enabled with driver off");
    chk_hold_length: assert property ($fell(drv_en) |-> hi_cnt >= 112)
        else $error("driver dropped before one character time");
    chk_rcv_drop_cause: assert property ($fell(rcv_en) |-> $rose(drv_en))
        else $error("receiver dropped without transmission");
    chk_apb_answer: assert property (psel && $rose(penable)
        && !(pwrite && paddr == `ADSP_OFS_DATA) |=> pready)
        else $error("APB answer late");
    chk_ready_pulse: assert property (pready |=> !pready)
        else $error("pready longer than one cycle");
    chk_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error answer malformed");
endmodule
bind adsp_top adsp_chk u_chk (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .range_4x(range_4x), .rxd(rxd), .txd(txd), .drv_en(drv_en),
    .rcv_en(rcv_en));
`default_nettype wire

/* File: dv/adsp_remote.sv */
/*
 Remote node on the shared pair: captures frames sent by the port at bit
 centres and sends frames back. Assumes bit_clks and nbits set by the bench.
*/
`timescale 1ns/10ps
`default_nettype none
module adsp_remote (
    // Clock
    input wire logic        clk_sys,
    // Line from the port
    input wire logic        txd,
    input wire logic        drv_en,
    // Bit timing
    input var  int          bit_clks,
    input var  int          nbits,
    // Line to the port and capture
    output var logic        rxd,
    output var logic [11:0] frame,
    output var int          nframes
);
    initial begin
        rxd = 1'b1;
        frame = 12'h000;
        nframes = 0;
    end
    // Bias holds the pair high, so idle is a driven one
    always begin : listen
        int k;
        @(posedge clk_sys);
        if (drv_en === 1'b1 && txd === 1'b0) begin
            frame = 12'h000;
            repeat (bit_clks / 2 - 1) @(posedge clk_sys);
            for (k = 0; k < nbits; k++) begin
                frame[k] = txd;
                if (k < nbits - 1)
                    repeat (bit_clks) @(posedge clk_sys);
            end
            nframes++;
        end
    end
    // Idle gap after the frame keeps a low stop from looking like a start
    task automatic send(input logic [11:0] bits, input int n);
        int k;
        while (drv_en !== 1'b0) @(posedge clk_sys);
        for (k = 0; k < n; k++) begin
            rxd <= bits[k];
            repeat (bit_clks) @(posedge clk_sys);
        end
        rxd <= 1'b1;
        repeat (2 * bit_clks) @(posedge clk_sys);
    endtask
endmodule
`default_nettype wire

/* File: dv/testbench.sv */
/*
 Self-checking bench for adsp_top: format table, burst through the transmit
 FIFO, receive errors, slow range. Assumes adsp_remote on the line.
*/
`timescale 1ns/10ps
`default_nettype none
`include "adsp_consts.vh"
module testbench;
    logic        clk_sys, rstn, psel, penable, pwrite, range_4x, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, rd;
    wire  [31:0] prdata;
    wire         pready, pslverr, txd, drv_en, rcv_en, rxd;
    wire  [11:0] frame;
    int          nframes, bit_clks, nbits, i, cnt, n0, cyc, failures, checks_done;
    // Rows: format, byte, expected driver-on cycles at one clock per tick
    logic [5:0]  fmt_tab [6] = '{6'h03, 6'h00, 6'h05, 6'h1e, 6'h27, 6'h2c};
    logic [7:0]  dat_tab [6] = '{8'ha5, 8'h13, 8'h2e, 8'h6b, 8'hc4, 8'h19};
    int          hold_tab [6] = '{320, 224, 288, 336, 384, 288};

    adsp_top uut (.clk_sys(clk_sys), .rstn(rstn), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .range_4x(range_4x), .rxd(rxd), .txd(txd),
        .drv_en(drv_en), .rcv_en(rcv_en));
    adsp_remote partner (.clk_sys(clk_sys), .txd(txd), .drv_en(drv_en), .bit_clks(bit_clks),
        .nbits(nbits), .rxd(rxd), .frame(frame), .nframes(nframes));

    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            failures++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task give_verdict;
        $display("checks %0d failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        @(posedge clk_sys);
        while (pready !== 1'b1) @(posedge clk_sys);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic run_drv(output int c);
        int w;
        c = 0;
        w = 0;
        while (drv_en !== 1'b1 && w < 100) begin
            @(posedge clk_sys);
            w++;
        end
        while (drv_en === 1'b1) begin
            @(posedge clk_sys);
            c++;
        end
    endtask

    function automatic logic [11:0] mkframe(input logic [5:0] f, input logic [7:0] b,
                                            input logic perr, input logic ferr);
        logic [11:0] r;
        int          l, k;
        l = 5 + f[1:0];
        r = 12'h000;
        for (k = 0; k < l; k++)
            r[1+k] = b[k];
        k = 1 + l;
        if (f[2]) begin
            r[k] = ^(b & (8'hff >> (8 - l))) ^ f[3] ^ perr;
            k++;
        end
        r[k] = ~ferr;
        return r;
    endfunction

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 30000) begin
            failures++;
            give_verdict;
        end
    end

    initial begin
        {rstn, psel, penable, pwrite, paddr, pwdata} = '0;
        range_4x = 1'b1;
        bit_clks = 16;
        nbits = 10;
        repeat (5) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        check("reset line", {txd, drv_en, rcv_en, pready}, 4'ha);
        apb(0, `ADSP_OFS_FORMAT, 0);
        check("format reset", rd, `ADSP_RST_FORMAT);
        apb(0, `ADSP_OFS_DIVISOR, 0);
        check("divisor reset", rd, `ADSP_RST_DIVISOR);
        apb(0, 12'h010, 0);
        check("unmapped err", er, 1'b1);
        check("unmapped data", rd, 32'h0);
        for (i = 0; i < 6; i++) begin
            nbits = 7 + fmt_tab[i][1:0] + fmt_tab[i][2];
            apb(1, `ADSP_OFS_FORMAT, fmt_tab[i]);
            apb(1, `ADSP_OFS_DATA, dat_tab[i]);
            run_drv(cnt);
            check("drv cycles", cnt, hold_tab[i]);
            check("frame", frame, mkframe(fmt_tab[i], dat_tab[i], 0, 0));
        end
        // Burst: one byte in the shifter, sixteen queued
        nbits = 10;
        apb(1, `ADSP_OFS_FORMAT, 6'h03);
        n0 = nframes;
        for (i = 0; i < 17; i++)
            apb(1, `ADSP_OFS_DATA, i);
        apb(0, `ADSP_OFS_STATUS, 0);
        check("tx full", rd[`ADSP_ST_TX_FULL], 1'b1);
        run_drv(cnt);
        check("burst count", nframes - n0, 17);
        check("burst last", frame, mkframe(6'h03, 8'h10, 0, 0));
        partner.send(mkframe(6'h03, 8'h5a, 0, 0), 10);
        apb(0, `ADSP_OFS_STATUS, 0);
        check("rx valid", rd[`ADSP_ST_RX_VALID], 1'b1);
        apb(0, `ADSP_OFS_DATA, 0);
        check("rx byte", rd, 32'h5a);
        apb(1, `ADSP_OFS_FORMAT, 6'h07);
        partner.send(mkframe(6'h07, 8'h3c, 1, 0), 11);
        apb(0, `ADSP_OFS_STATUS, 0);
        check("parity err", rd[`ADSP_ST_PAR_ERR], 1'b1);
        partner.send(mkframe(6'h07, 8'h3c, 0, 1), 11);
        apb(0, `ADSP_OFS_STATUS, 0);
        check("framing err", rd[`ADSP_ST_FRM_ERR], 1'b1);
        apb(1, `ADSP_OFS_STATUS, 32'h700);
        apb(0, `ADSP_OFS_STATUS, 0);
        check("errors cleared", rd[10:8], 3'h0);
        // Slow range, divisor 2: tick every 8 clocks
        apb(1, `ADSP_OFS_FORMAT, 6'h03);
        apb(1, `ADSP_OFS_DIVISOR, 2);
        range_4x <= 1'b0;
        bit_clks = 128;
        apb(1, `ADSP_OFS_DATA, 8'h96);
        run_drv(cnt);
        check("slow drv cycles", cnt, 2560);
        check("slow frame", frame, mkframe(6'h03, 8'h96, 0, 0));
        // Reset in mid-frame: line let go at once, divisor back to its reset value
        apb(1, `ADSP_OFS_DATA, 8'h55);
        apb(0, `ADSP_OFS_STATUS, 0);
        check("status driving", rd[`ADSP_ST_RCV_EN:`ADSP_ST_TX_BUSY], 3'h3);
        repeat (40) @(posedge clk_sys);
        check("busy before reset", drv_en, 1'b1);
        rstn <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rstn <= 1'b1;
        @(posedge clk_sys);
        check("mid reset line", {txd, drv_en, rcv_en, pready}, 4'ha);
        apb(0, `ADSP_OFS_DIVISOR, 0);
        check("mid reset divisor", rd, `ADSP_RST_DIVISOR);
        give_verdict;
    end
endmodule
`default_nettype wire
